// ### src/djkff_cfg.svh
// Purpose: constants for the dual j-k flip-flop block
// Assumes: one system clock, synchronous active-high reset
// Notes:   control encodings and reset levels
`ifndef DJKFF_CFG_SVH
`define DJKFF_CFG_SVH
`define DJKFF_NUM_FF    2
`define DJKFF_Q_CLEAR   1'h0
`define DJKFF_PIN_RST   1'h1
`define DJKFF_CTL_HOLD  2'h0
`define DJKFF_CTL_RESET 2'h1
`define DJKFF_CTL_SET   2'h2
`define DJKFF_CTL_TOG   2'h3
`endif

// ### src/djkff_pkg.sv
// Purpose: types for the dual j-k flip-flop block
// Assumes: constants come from djkff_cfg.svh
// Notes:   control code is {j, k}
package djkff_pkg;
  typedef logic [1:0] djkff_ctl_type;
endpackage

// ### src/djkff_top.sv
// Purpose: two independent falling-edge j-k flip-flops with clear
// Assumes: all pins are asynchronous to clk and are synchronised here
// Notes:   pin edges are seen two to three clk cycles late
//
// Behaviour
// - two flip-flops, fully independent inputs and state
// - low clear forces true low, inverted high
// - outputs change only on falling clock edge or low clear
// - jk: hold, reset, set, toggle on edge
// - j and k between falling edges are ignored
`timescale 1ns/10ps
`include "djkff_cfg.svh"
module djkff_top
  import djkff_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] ff_clk,
  input  wire logic [1:0] async_clear_n,
  input  wire logic [1:0] j_in,
  input  wire logic [1:0] k_in,
  output logic      [1:0] q_out,
  output logic      [1:0] q_n_out
);

  function automatic logic djkff_next(input logic q, input djkff_ctl_type c);
    logic r;
    r = q;
    unique case (c)
      `DJKFF_CTL_HOLD:  r = q;
      `DJKFF_CTL_RESET: r = 1'h0;
      `DJKFF_CTL_SET:   r = 1'h1;
      `DJKFF_CTL_TOG:   r = ~q;
    endcase
    return r;
  endfunction

  // two-stage synchronisers; stage one feeds only stage two
  logic [1:0] clk_s1_r, clk_s2_r, clk_d_r;
  logic [1:0] clr_s1_r, clr_s2_r;
  logic [1:0] j_s1_r,   j_s2_r;
  logic [1:0] k_s1_r,   k_s2_r;
  logic [1:0] q_r;
  logic [1:0] clk_d_nxt;
  logic [1:0] q_nxt;
  logic [1:0] fall;

  // next values of the synchroniser chains
  logic [1:0] clk_s1_nxt, clk_s2_nxt;
  logic [1:0] clr_s1_nxt, clr_s2_nxt;
  logic [1:0] j_s1_nxt,   j_s2_nxt;
  logic [1:0] k_s1_nxt,   k_s2_nxt;

  // stage two reads only stage one, so no logic sees a metastable bit
  always_comb begin
    clk_s1_nxt = ff_clk;
    clk_s2_nxt = clk_s1_r;
    clr_s1_nxt = async_clear_n;
    clr_s2_nxt = clr_s1_r;
    j_s1_nxt   = j_in;
    j_s2_nxt   = j_s1_r;
    k_s1_nxt   = k_in;
    k_s2_nxt   = k_s1_r;
  end

  // pins reset to their idle levels so release makes no false fall
  always_ff @(posedge clk) begin
    if (rst) begin
      clk_s1_r <= {`DJKFF_NUM_FF{`DJKFF_PIN_RST}};
      clk_s2_r <= {`DJKFF_NUM_FF{`DJKFF_PIN_RST}};
      clr_s1_r <= {`DJKFF_NUM_FF{`DJKFF_PIN_RST}};
      clr_s2_r <= {`DJKFF_NUM_FF{`DJKFF_PIN_RST}};
      j_s1_r   <= {`DJKFF_NUM_FF{`DJKFF_Q_CLEAR}};
      j_s2_r   <= {`DJKFF_NUM_FF{`DJKFF_Q_CLEAR}};
      k_s1_r   <= {`DJKFF_NUM_FF{`DJKFF_Q_CLEAR}};
      k_s2_r   <= {`DJKFF_NUM_FF{`DJKFF_Q_CLEAR}};
    end else begin
      clk_s1_r <= clk_s1_nxt;
      clk_s2_r <= clk_s2_nxt;
      clr_s1_r <= clr_s1_nxt;
      clr_s2_r <= clr_s2_nxt;
      j_s1_r   <= j_s1_nxt;
      j_s2_r   <= j_s2_nxt;
      k_s1_r   <= k_s1_nxt;
      k_s2_r   <= k_s2_nxt;
    end
  end

  // j and k travel the same path as the clock, so levels at the edge line up
  always_comb begin
    clk_d_nxt = clk_s2_r;
    fall      = clk_d_r & ~clk_s2_r;
    q_nxt     = q_r;
    for (int i = 0; i < `DJKFF_NUM_FF; i++) begin
      if (!clr_s2_r[i]) begin
        q_nxt[i] = `DJKFF_Q_CLEAR;
      end else if (fall[i]) begin
        q_nxt[i] = djkff_next(q_r[i], {j_s2_r[i], k_s2_r[i]});
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clk_d_r <= {`DJKFF_NUM_FF{`DJKFF_PIN_RST}};
      q_r     <= {`DJKFF_NUM_FF{`DJKFF_Q_CLEAR}};
    end else begin
      clk_d_r <= clk_d_nxt;
      q_r     <= q_nxt;
    end
  end

  // the live clear pin is also gated in so clear acts without any clk delay
  assign q_out   = q_r & async_clear_n;
  assign q_n_out = ~q_out;

  chk_edge_only_q: assert property (@(posedge clk)
    disable iff (rst)
    (clr_s2_r[0] && !fall[0]) |=> q_r[0] == $past(q_r[0]))
    else $error("q0 changed without falling edge");

  chk_edge_only_q1: assert property (@(posedge clk)
    disable iff (rst)
    (clr_s2_r[1] && !fall[1]) |=> q_r[1] == $past(q_r[1]))
    else $error("q1 changed without falling edge");

  chk_rise_q0: assert property (@(posedge clk)
    disable iff (rst)
    (clr_s2_r[0] && clk_s2_r[0] && !clk_d_r[0]) |=> $stable(q_r[0]))
    else $error("q0 moved on rising edge");

  chk_rise_q1: assert property (@(posedge clk)
    disable iff (rst)
    (clr_s2_r[1] && clk_s2_r[1] && !clk_d_r[1]) |=> $stable(q_r[1]))
    else $error("q1 moved on rising edge");

  chk_fall_single0: assert property (@(posedge clk)
    disable iff (rst)
    fall[0] |=> !fall[0])
    else $error("ff0 fall seen twice");

  chk_fall_single1: assert property (@(posedge clk)
    disable iff (rst)
    fall[1] |=> !fall[1])
    else $error("ff1 fall seen twice");

  chk_hold_q0: assert property (@(posedge clk)
    disable iff (rst)
    (clr_s2_r[0] && fall[0] && !j_s2_r[0] && !k_s2_r[0])
      |=> q_r[0] == $past(q_r[0]))
    else $error("q0 did not hold");

  chk_hold_q1: assert property (@(posedge clk)
    disable iff (rst)
    (clr_s2_r[1] && fall[1] && !j_s2_r[1] && !k_s2_r[1])
      |=> q_r[1] == $past(q_r[1]))
    else $error("q1 did not hold");

  chk_toggle_q: assert property (@(posedge clk)
    disable iff (rst)
    (clr_s2_r[1] && fall[1] && j_s2_r[1] && k_s2_r[1])
      |=> q_r[1] != $past(q_r[1]))
    else $error("q1 did not toggle");

  chk_toggle_q0: assert property (@(posedge clk)
    disable iff (rst)
    (clr_s2_r[0] && fall[0] && j_s2_r[0] && k_s2_r[0])
      |=> q_r[0] != $past(q_r[0]))
    else $error("q0 did not toggle");

  chk_set_q: assert property (@(posedge clk)
    disable iff (rst)
    (clr_s2_r[0] && fall[0] && j_s2_r[0] && !k_s2_r[0]) |=> q_r[0])
    else $error("q0 not set");

  chk_set_q1: assert property (@(posedge clk)
    disable iff (rst)
    (clr_s2_r[1] && fall[1] && j_s2_r[1] && !k_s2_r[1]) |=> q_r[1])
    else $error("q1 not set");

  chk_reset_q: assert property (@(posedge clk)
    disable iff (rst)
    (clr_s2_r[1] && fall[1] && !j_s2_r[1] && k_s2_r[1]) |=> !q_r[1])
    else $error("q1 not reset");

  chk_reset_q0: assert property (@(posedge clk)
    disable iff (rst)
    (clr_s2_r[0] && fall[0] && !j_s2_r[0] && k_s2_r[0]) |=> !q_r[0])
    else $error("q0 not reset");

  chk_clear_out: assert property (@(posedge clk)
    disable iff (rst)
    !async_clear_n[0] |-> !q_out[0] && q_n_out[0])
    else $error("clear not forcing outputs");

  chk_clear_out1: assert property (@(posedge clk)
    disable iff (rst)
    !async_clear_n[1] |-> !q_out[1] && q_n_out[1])
    else $error("clear not forcing ff1 outputs");

  chk_clear_state: assert property (@(posedge clk)
    disable iff (rst)
    !clr_s2_r[1] |=> !q_r[1])
    else $error("clear not resetting state");

  chk_clear_state0: assert property (@(posedge clk)
    disable iff (rst)
    !clr_s2_r[0] |=> !q_r[0])
    else $error("clear not resetting ff0 state");

  chk_complement_out: assert property (@(posedge clk)
    disable iff (rst)
    q_n_out == ~q_out)
    else $error("outputs not complementary");

  chk_indep_ff: assert property (@(posedge clk)
    disable iff (rst)
    (clr_s2_r[1] && !fall[1]) |=> $stable(q_r[1]))
    else $error("ff1 disturbed");

  chk_indep_ff0: assert property (@(posedge clk)
    disable iff (rst)
    (clr_s2_r[0] && !fall[0]) |=> $stable(q_r[0]))
    else $error("ff0 disturbed");
endmodule

// ### verification/djkff_board.sv
// Purpose: board logic driving one flip-flop's pins
// Assumes: pins move 1 ns after clk rises
// Notes:   clock idles high, so reset sees no false fall
`timescale 1ns/10ps
module djkff_board (
  input  wire logic clk,
  output logic      pin_clk,
  output logic      pin_clr_n,
  output logic      pin_j,
  output logic      pin_k
);
  initial {pin_clk, pin_clr_n, pin_j, pin_k} = 4'hC;
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic clear(input logic lvl);
    step(1);
    pin_clr_n = lvl;
  endtask
  // j and k flip once the fall is taken, which must not matter
  task automatic fall(input logic [1:0] jk);
    step(1);
    {pin_j, pin_k} = jk;
    step(2);
    pin_clk = 1'h0;
    step(2);
    {pin_j, pin_k} = ~jk;
    step(3);
    pin_clk = 1'h1;
    step(4);
  endtask
endmodule

// ### verification/testbench.sv
// Purpose: self-checking bench for the dual j-k flip-flop block
// Assumes: q settles 3 clk cycles after a pin edge
// Notes:   one flip-flop idles while the other runs
`timescale 1ns/10ps
module testbench;
  logic       clk = 1'h0;
  logic       rst = 1'h1;
  wire  [1:0] ff_clk;
  wire  [1:0] clr_n;
  wire  [1:0] j;
  wire  [1:0] k;
  logic [1:0] q;
  logic [1:0] q_n;
  int         failures = 0;
  int         checked = 0;
  int         cycles = 0;
  always #2 clk = ~clk;
  djkff_board i_b0 (.clk(clk), .pin_clk(ff_clk[0]), .pin_clr_n(clr_n[0]),
    .pin_j(j[0]), .pin_k(k[0]));
  djkff_board i_b1 (.clk(clk), .pin_clk(ff_clk[1]), .pin_clr_n(clr_n[1]),
    .pin_j(j[1]), .pin_k(k[1]));
  djkff_top i_dut (.clk(clk), .rst(rst), .ff_clk(ff_clk),
    .async_clear_n(clr_n), .j_in(j), .k_in(k), .q_out(q), .q_n_out(q_n));
  task automatic final_report();
    if (failures == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic expect_q(input logic [1:0] exp);
    checked++;
    if (q !== exp) begin
      failures++;
      $display("mismatch q_out exp %h seen %h", exp, q);
    end
    checked++;
    if (q_n !== ~exp) begin
      failures++;
      $display("mismatch q_n_out exp %h seen %h", ~exp, q_n);
    end
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      failures++;
      final_report();
    end
  end
  task automatic run_jk();
    logic [1:0] code [5] = '{2'h2, 2'h0, 2'h1, 2'h3, 2'h3};
    logic [1:0] want [5] = '{2'h1, 2'h1, 2'h0, 2'h1, 2'h0};
    for (int n = 0; n < 5; n++) begin
      i_b0.fall(code[n]);
      expect_q(want[n]);
    end
  endtask
  task automatic run_clear();
    i_b1.fall(2'h2);
    expect_q(2'h2);
    i_b1.clear(1'h0);
    #1 expect_q(2'h0);
    i_b1.fall(2'h3);
    expect_q(2'h0);
    i_b1.clear(1'h1);
    i_b1.fall(2'h3);
    expect_q(2'h2);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 1'h0;
    expect_q(2'h0);
    run_jk();
    run_clear();
    final_report();
  end
endmodule
